// ---- hw/twsp_cfg.svh ----
// constants and operating summary for the three-wire serial port
// Summary of operation
// - A transfer runs from the rise to the fall of the enable input, and the bus is ignored while it is low.
// - One data pin carries address and write data in and read data out.
// - Incoming bits are taken on the rising shift-clock edge, outgoing bits change on the falling edge.
// - One bit per shift-clock period, grouped into eight-bit units for address and data.
// - Address and write-data bytes arrive least significant bit first.
// - Read data bytes leave on the data pin least significant bit first.
// - The first byte after the enable rises is the address byte, followed by one or more data bytes.
// - The top address bit picks the direction for the whole transfer: 0 reads, 1 writes.
// - The register pointer advances by one after each data byte read or written.
// - The pointer keeps advancing on every byte until the enable falls.
// - A read burst wraps from the highest read address back to the lowest.
// - A write burst wraps from the highest write address back to the lowest.
// - The time snapshot is reloaded from the live counters only when the enable rises.
// - Read and write addresses of a register differ only in the top bit.
`ifndef TWSP_CFG_SVH
`define TWSP_CFG_SVH

// ----------------------------------------
// framing and addressing
// ----------------------------------------
`define TWSP_BYTE_W 8
`define TWSP_BIT_CNT_W 3
`define TWSP_LAST_BIT 3'h7
`define TWSP_DIR_BIT 7
`define TWSP_DIR_WRITE 1'h1
`define TWSP_PTR_W 4
`define TWSP_NREG 16
`define TWSP_TIME_BYTES 8
`define TWSP_SYNC_STAGES 2
`define TWSP_PTR_STEP 4'h1
`define TWSP_BYTE_ZERO 8'h00

`endif

// ---- hw/twsp_pkg.sv ----
// types shared by the three-wire serial port files
`include "twsp_cfg.svh"
package twsp_pkg;

  // ----------------------------------------
  // port state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    TWSP_IDLE,
    TWSP_ADDR,
    TWSP_READ,
    TWSP_WRITE
  } twsp_state_t;

  // ----------------------------------------
  // register write strobe carried to the core
  // ----------------------------------------
  typedef struct packed {
    logic [`TWSP_PTR_W-1:0] addr;
    logic [`TWSP_BYTE_W-1:0] data;
  } twsp_wr_t;

endpackage

// ---- hw/twsp_sync.sv ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
`include "twsp_cfg.svh"
module twsp_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------
  // per-bit flop chain
  // ----------------------------------------
  // first stage is read only by the second to keep metastability contained
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
      logic [`TWSP_SYNC_STAGES-1:0] chain_reg;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          chain_reg <= '0;
        end else begin
          chain_reg <= {chain_reg[`TWSP_SYNC_STAGES-2:0], din[g]};
        end
      end
      assign dout[g] = chain_reg[`TWSP_SYNC_STAGES-1];
    end
  endgenerate

endmodule
`default_nettype wire

// ---- hw/twsp_regmem.sv ----
// register store with time snapshot and registered read port
`timescale 1ns/10ps
`default_nettype none
`include "twsp_cfg.svh"
module twsp_regmem #(
  parameter int NREG = `TWSP_NREG,
  parameter int TIME_BYTES = `TWSP_TIME_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic snap,
  input wire logic [TIME_BYTES*`TWSP_BYTE_W-1:0] live_time,
  input wire logic wr_en,
  input wire twsp_pkg::twsp_wr_t wr,
  input wire logic [`TWSP_PTR_W-1:0] rd_addr,
  output logic [`TWSP_BYTE_W-1:0] rd_data
);

  logic [`TWSP_BYTE_W-1:0] mem_reg [NREG];

  // ----------------------------------------
  // storage: snapshot load and serial writes
  // ----------------------------------------
  // a write in the snapshot cycle cannot occur: snap only fires as a frame opens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        mem_reg[i] <= `TWSP_BYTE_ZERO;
      end
    end else if (snap) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        mem_reg[i] <= live_time[i*`TWSP_BYTE_W +: `TWSP_BYTE_W];
      end
    end else if (wr_en) begin
      mem_reg[wr.addr] <= wr.data;
    end
  end

  // ----------------------------------------
  // read port, one cycle of latency
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= `TWSP_BYTE_ZERO;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ---- hw/twsp_port.sv ----
// three-wire serial port, slave side, with register store
`timescale 1ns/10ps
`default_nettype none
`include "twsp_cfg.svh"
module twsp_port #(
  parameter int TIME_BYTES = `TWSP_TIME_BYTES
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // pins to and from the bus master
  input wire logic CE_PIN,
  input wire logic SCLK_PIN,
  input wire logic IO_IN,
  output logic IO_OUT,
  output logic IO_OE_N,
  // live time counters and register write strobe to the core
  input wire logic [TIME_BYTES*`TWSP_BYTE_W-1:0] LIVE_TIME,
  output logic WR_VALID,
  output var twsp_pkg::twsp_wr_t WR,
  output logic BUSY
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pins_sync;
  logic ce_s;
  logic sclk_s;
  logic io_s;

  twsp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .din({CE_PIN, SCLK_PIN, IO_IN}),
    .dout(pins_sync)
  );

  assign ce_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign io_s = pins_sync[0];

  // ----------------------------------------
  // edge detection on the synchronised pins
  // ----------------------------------------
  logic ce_d_reg;
  logic sclk_d_reg;

  // delayed copies, taken from the synchroniser output only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ce_d_reg <= 1'h0;
      sclk_d_reg <= 1'h0;
    end else begin
      ce_d_reg <= ce_s;
      sclk_d_reg <= sclk_s;
    end
  end

  logic ce_rise;
  logic ce_fall;
  logic sclk_rise;
  logic sclk_fall;

  assign ce_rise = ce_s & ~ce_d_reg;
  assign ce_fall = ~ce_s & ce_d_reg;
  // shift-clock edges count only inside a frame; outside it the bus is ignored
  assign sclk_rise = ce_s & ce_d_reg & sclk_s & ~sclk_d_reg;
  assign sclk_fall = ce_s & ce_d_reg & ~sclk_s & sclk_d_reg;

  // ----------------------------------------
  // state and datapath registers
  // ----------------------------------------
  twsp_pkg::twsp_state_t state_reg;
  twsp_pkg::twsp_state_t state_next;
  logic [`TWSP_BYTE_W-1:0] in_sh_reg;
  logic [`TWSP_BYTE_W-1:0] in_sh_next;
  logic [`TWSP_BIT_CNT_W-1:0] in_cnt_reg;
  logic [`TWSP_BIT_CNT_W-1:0] in_cnt_next;
  logic [`TWSP_BYTE_W-1:0] out_sh_reg;
  logic [`TWSP_BYTE_W-1:0] out_sh_next;
  logic [`TWSP_BIT_CNT_W-1:0] out_cnt_reg;
  logic [`TWSP_BIT_CNT_W-1:0] out_cnt_next;
  logic [`TWSP_PTR_W-1:0] ptr_reg;
  logic [`TWSP_PTR_W-1:0] ptr_next;
  logic io_out_next;
  logic oe_n_next;
  logic wr_valid_next;
  twsp_pkg::twsp_wr_t wr_next;
  logic [`TWSP_BYTE_W-1:0] rd_data;

  // ----------------------------------------
  // input byte assembly
  // ----------------------------------------
  logic [`TWSP_BYTE_W-1:0] in_byte;
  logic byte_done;

  // new bit enters at the top so the first bit ends in bit 0
  assign in_byte = {io_s, in_sh_reg[`TWSP_BYTE_W-1:1]};
  assign byte_done = sclk_rise && (in_cnt_reg == `TWSP_LAST_BIT);

  // ----------------------------------------
  // address byte decode
  // ----------------------------------------
  logic addr_is_write;
  logic [`TWSP_PTR_W-1:0] addr_index;

  // the top bit is direction; read and write views share the low index
  assign addr_is_write = (in_byte[`TWSP_DIR_BIT] == `TWSP_DIR_WRITE);
  assign addr_index = in_byte[`TWSP_PTR_W-1:0];

  // ----------------------------------------
  // output byte selection
  // ----------------------------------------
  logic out_load;
  logic [`TWSP_BYTE_W-1:0] out_src;
  logic [`TWSP_PTR_W-1:0] ptr_inc;

  // a fresh byte is taken from the store at the first falling edge of each byte
  assign out_load = (out_cnt_reg == '0);
  assign out_src = out_load ? rd_data : out_sh_reg;
  // four-bit pointer rolls over within the sixteen-register window
  assign ptr_inc = ptr_reg + `TWSP_PTR_STEP;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    in_sh_next = in_sh_reg;
    in_cnt_next = in_cnt_reg;
    out_sh_next = out_sh_reg;
    out_cnt_next = out_cnt_reg;
    ptr_next = ptr_reg;
    io_out_next = IO_OUT;
    oe_n_next = IO_OE_N;
    wr_valid_next = 1'h0;
    wr_next = WR;
    if (!ce_s) begin
      // frame over: release the pin at once, whatever the phase
      state_next = twsp_pkg::TWSP_IDLE;
      oe_n_next = 1'h1;
      io_out_next = 1'h0;
    end else if (ce_rise) begin
      // every frame opens with an address byte
      state_next = twsp_pkg::TWSP_ADDR;
      in_cnt_next = '0;
      out_cnt_next = '0;
      oe_n_next = 1'h1;
    end else begin
      if (sclk_rise) begin
        in_sh_next = in_byte;
        in_cnt_next = in_cnt_reg + 3'h1;
      end
      unique case (state_reg)
        twsp_pkg::TWSP_IDLE: begin
          oe_n_next = 1'h1;
        end
        twsp_pkg::TWSP_ADDR: begin
          if (byte_done) begin
            ptr_next = addr_index;
            state_next = addr_is_write ? twsp_pkg::TWSP_WRITE : twsp_pkg::TWSP_READ;
          end
        end
        twsp_pkg::TWSP_WRITE: begin
          if (byte_done) begin
            wr_valid_next = 1'h1;
            wr_next.addr = ptr_reg;
            wr_next.data = in_byte;
            ptr_next = ptr_inc;
          end
        end
        twsp_pkg::TWSP_READ: begin
          if (sclk_fall) begin
            // drive on the falling edge so the bit is steady at the next rise
            oe_n_next = 1'h0;
            io_out_next = out_src[0];
            out_sh_next = {1'h0, out_src[`TWSP_BYTE_W-1:1]};
            out_cnt_next = out_cnt_reg + 3'h1;
            if (out_load) begin
              ptr_next = ptr_inc;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= twsp_pkg::TWSP_IDLE;
      in_sh_reg <= `TWSP_BYTE_ZERO;
      in_cnt_reg <= '0;
      out_sh_reg <= `TWSP_BYTE_ZERO;
      out_cnt_reg <= '0;
      ptr_reg <= '0;
    end else begin
      state_reg <= state_next;
      in_sh_reg <= in_sh_next;
      in_cnt_reg <= in_cnt_next;
      out_sh_reg <= out_sh_next;
      out_cnt_reg <= out_cnt_next;
      ptr_reg <= ptr_next;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // all pins and strobes come straight from flops to avoid glitches
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IO_OUT <= 1'h0;
      IO_OE_N <= 1'h1;
      WR_VALID <= 1'h0;
      WR <= '0;
      BUSY <= 1'h0;
    end else begin
      IO_OUT <= io_out_next;
      IO_OE_N <= oe_n_next;
      WR_VALID <= wr_valid_next;
      WR <= wr_next;
      BUSY <= ce_s;
    end
  end

  // ----------------------------------------
  // register store
  // ----------------------------------------
  // snapshot only at frame start, so a burst reads one frozen time
  twsp_regmem #(
    .NREG(`TWSP_NREG),
    .TIME_BYTES(TIME_BYTES)
  ) u_mem (
    .clk(CLOCK),
    .rst(SYS_RST),
    .snap(ce_rise),
    .live_time(LIVE_TIME),
    .wr_en(wr_valid_next),
    .wr(wr_next),
    .rd_addr(ptr_reg),
    .rd_data(rd_data)
  );

endmodule
`default_nettype wire

// ---- dv/twsp_chk.sv ----
// assertions on the ports of the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
`include "twsp_cfg.svh"
module twsp_chk #(
  parameter int TIME_BYTES = `TWSP_TIME_BYTES
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CE_PIN,
  input wire logic SCLK_PIN,
  input wire logic IO_IN,
  input wire logic IO_OUT,
  input wire logic IO_OE_N,
  input wire logic [TIME_BYTES*`TWSP_BYTE_W-1:0] LIVE_TIME,
  input wire logic WR_VALID,
  input wire twsp_pkg::twsp_wr_t WR,
  input wire logic BUSY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic [3:0] last_reg;
  logic seen_reg;
  // last write index of this frame; a drop of busy starts afresh
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_reg <= 4'h0;
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= BUSY && (seen_reg || WR_VALID);
      if (WR_VALID) last_reg <= WR.addr;
    end
  end
  sequence s_ce_rise;
    !CE_PIN ##1 CE_PIN;
  endsequence
  sequence s_ce_idle;
    !CE_PIN [*6];
  endsequence
  a_busy_follow: assert property (s_ce_rise |-> ##[2:4] BUSY)
    else $error("busy late after enable rise");
  a_idle_release: assert property (s_ce_idle |-> IO_OE_N && !BUSY && !IO_OUT)
    else $error("pin or busy held while enable low");
  a_oe_in_frame: assert property (!IO_OE_N |-> BUSY)
    else $error("pin driven outside a frame");
  a_out_on_fall: assert property ($changed(IO_OUT) || $fell(IO_OE_N) |-> !SCLK_PIN)
    else $error("read bit changed with shift clock high");
  a_wr_pulse: assert property (WR_VALID |=> !WR_VALID)
    else $error("write strobe longer than one cycle");
  a_wr_hold: assert property (!WR_VALID |-> $stable(WR))
    else $error("write bus moved without strobe");
  a_wr_in_frame: assert property (WR_VALID |-> BUSY)
    else $error("write outside a frame");
  a_ptr_step: assert property (WR_VALID && seen_reg |-> WR.addr == last_reg + 4'h1)
    else $error("write index did not step by one");
  c_wr_wrap: cover property (WR_VALID && seen_reg && WR.addr == 4'h0);
endmodule
bind twsp_port twsp_chk #(.TIME_BYTES(TIME_BYTES)) twsp_chk_inst (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .CE_PIN(CE_PIN), .SCLK_PIN(SCLK_PIN), .IO_IN(IO_IN), .IO_OUT(IO_OUT),
  .IO_OE_N(IO_OE_N), .LIVE_TIME(LIVE_TIME), .WR_VALID(WR_VALID), .WR(WR), .BUSY(BUSY));
`default_nettype wire

// ---- dv/twsp_mst.sv ----
// bus master model: enable, shift clock and data pin
`timescale 1ns/10ps
`default_nettype none
module twsp_mst (
  output logic ce,
  output logic sclk,
  output logic m_oe,
  output logic m_do,
  input wire logic io
);
  logic [7:0] rd_q[$];
  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    m_oe = 1'b0;
    m_do = 1'b0;
  end
  // one frame; shift clock stands low outside it, 125 ns per bit
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wd[$], input int n);
    logic [7:0] sh;
    rd_q = {};
    ce <= 1'b1;
    for (int b = 0; b <= n; b++) begin
      sh = (b == 0) ? addr : (addr[7] ? wd[b-1] : 8'h00);
      m_oe <= (b == 0) || addr[7];
      for (int i = 0; i < 8; i++) begin
        m_do <= sh[i];
        #62.5 sclk <= 1'b1;
        sh[i] = io;
        #62.5 sclk <= 1'b0;
      end
      if (b > 0 && !addr[7]) rd_q.push_back(sh);
    end
    ce <= 1'b0;
    m_oe <= 1'b0;
    #250;
  endtask
endmodule
`default_nettype wire

// ---- dv/twsp_port_tb.sv ----
// self-checking bench for the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module twsp_port_tb;
  logic CLOCK, SYS_RST, junk;
  logic [63:0] live;
  wire logic ce, sclk, m_oe, m_do, io_w, IO_OUT, IO_OE_N, WR_VALID, BUSY;
  twsp_pkg::twsp_wr_t WR;
  int err_total, tests_run, cyc, seed;
  logic [7:0] mdl[16];
  logic [11:0] wr_q[$];
  logic [3:0] a;
  // released wire shows a toggling pattern, never the last value
  assign io_w = !IO_OE_N ? IO_OUT : (m_oe ? m_do : junk);
  twsp_port twsp_port_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CE_PIN(ce), .SCLK_PIN(sclk),
    .IO_IN(io_w), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .LIVE_TIME(live),
    .WR_VALID(WR_VALID), .WR(WR), .BUSY(BUSY));
  twsp_mst twsp_mst_inst (.ce(ce), .sclk(sclk), .m_oe(m_oe), .m_do(m_do), .io(io_w));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one frame against the model; snapshot reloads at every start
  task automatic frame(input logic [7:0] ad, input int n);
    logic [7:0] wd[$];
    logic [3:0] p;
    p = ad[3:0];
    wd = {};
    wr_q = {};
    for (int k = 0; k < 8; k++) mdl[k] = live[8*k +: 8];
    for (int k = 0; k < n; k++) wd.push_back(8'($random(seed)));
    twsp_mst_inst.xfer(ad, wd, n);
    for (int k = 0; k < n; k++) begin
      if (ad[7]) begin
        check(wr_q[k], {p, wd[k]});
        mdl[p] = wd[k];
      end else check({4'h0, twsp_mst_inst.rd_q[k]}, {4'h0, mdl[p]});
      p = p + 4'h1;
    end
    check(12'(wr_q.size()), ad[7] ? 12'(n) : 12'h000);
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // monitor, pin contention and run limit
  always @(posedge CLOCK) begin
    junk <= ~junk;
    cyc <= cyc + 1;
    if (WR_VALID === 1'b1) wr_q.push_back(WR);
    if (m_oe && ce) check({11'h000, IO_OE_N}, 12'h001);
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    SYS_RST = 1'b1;
    junk = 1'b0;
    live = 64'h0;
    cyc = 0;
    err_total = 0;
    tests_run = 0;
    seed = 2118;
    foreach (mdl[k]) mdl[k] = 8'h00;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    check({9'h000, IO_OE_N, WR_VALID, BUSY}, 12'h004);
    live <= {$random(seed), $random(seed)};
    repeat (5) @(posedge CLOCK);
    frame(8'h8E, 4);
    frame(8'h0E, 4);
    // time moves mid-burst; the frozen copy must not follow
    fork
      frame(8'h00, 10);
      begin
        repeat (300) @(posedge CLOCK);
        live <= {$random(seed), $random(seed)};
      end
    join
    frame(8'h00, 8);
    for (int k = 0; k < 4; k++) begin
      a = 4'($random(seed));
      frame({1'b1, 3'($random(seed)), a}, 1);
      frame({4'h0, a}, 1);
    end
    summarize();
  end
endmodule
`default_nettype wire
